// file: flsrc_pkg.sv
package flsrc_pkg;

  // clock rate and software reset interval
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RESET_TIME_NS = 30000;
  localparam int unsigned RESET_CYCLES =
    (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = $clog2(RESET_CYCLES + 1);

  // command opcodes
  localparam logic [7:0] OP_READ_SECREG   = 8'h48;
  localparam logic [7:0] OP_LOCK_UNIT     = 8'h36;
  localparam logic [7:0] OP_UNLOCK_UNIT   = 8'h39;
  localparam logic [7:0] OP_READ_LOCK     = 8'h3D;
  localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE  = 8'h99;

  // frame lengths and address field positions
  localparam int unsigned OPCODE_BITS    = 8;
  localparam int unsigned ADDR_BITS      = 24;
  localparam int unsigned DUMMY_BITS     = 8;
  localparam int unsigned UNIT_LSB       = 16;
  localparam int unsigned SECREG_SEL_LSB = 12;

  // storage sizes and reset values
  localparam int unsigned LOCK_UNITS = 64;
  localparam int unsigned UNIT_W     = 6;
  localparam int unsigned MEM_AW     = 10;
  localparam int unsigned BUF_DEPTH  = 2;
  localparam logic        LOCK_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_OPCODE    = 3'b001,
    ST_ADDR      = 3'b010,
    ST_DUMMY     = 3'b011,
    ST_OUT       = 3'b100,
    ST_WAIT_CS   = 3'b101,
    ST_RESETTING = 3'b110
  } flsrc_phase_type;

  typedef struct packed {
    logic              en;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        data;
  } flsrc_memwr_type;

  typedef struct packed {
    logic busy;
    logic soft_reset;
    logic reset_armed;
  } flsrc_status_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } flsrc_memrd_type;

  typedef struct packed {
    logic [2:0]                cs_s;
    logic [2:0]                sck_s;
    logic [2:0]                di_s;
    logic                      cs_f;
    logic                      sck_f;
    flsrc_phase_type           phase;
    logic [7:0]                opcode;
    logic [ADDR_BITS-1:0]      addr;
    logic [4:0]                bit_cnt;
    logic                      frame_ok;
    logic [7:0]                out_sh;
    logic [2:0]                out_cnt;
    logic                      do_bit;
    logic [7:0]                rd_byte;
    logic                      inflight;
    logic [BUF_DEPTH-1:0][7:0] buf_data;
    logic [1:0]                buf_cnt;
    logic [LOCK_UNITS-1:0]     lock;
    logic                      rst_armed;
    logic [RST_CNT_W-1:0]      rst_cnt;
    logic                      soft_pulse;
  } flsrc_state_type;

endpackage

// file: flsrc_mem.sv
`timescale 1ns/100ps
module flsrc_mem
  import flsrc_pkg::*;
#(
  parameter int unsigned AW = MEM_AW,
  parameter int unsigned DW = 8
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // loader write port
  input  wire flsrc_memwr_type wr,
  // read port
  input  wire logic            rd_en,
  input  wire logic [AW-1:0]   rd_addr,
  output logic [DW-1:0]        rd_data,
  output logic                 rd_valid
);

  logic [DW-1:0]   mem [2**AW];
  flsrc_memrd_type rd_reg;
  flsrc_memrd_type rd_next;

  // array write from the loader, no reset on the array itself
  always_ff @(posedge clk)
  begin
    if (wr.en)
      mem[wr.addr] <= wr.data;
  end

  // registered read, valid one cycle after the request
  always_comb
  begin
    rd_next       = rd_reg;
    rd_next.valid = rd_en;
    if (rd_en)
      rd_next.data = mem[rd_addr];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_reg <= '0;
    else
      rd_reg <= rd_next;
  end

  assign rd_data  = rd_reg.data;
  assign rd_valid = rd_reg.valid;

endmodule

// file: flsrc_core.sv
`timescale 1ns/100ps
module flsrc_core
  import flsrc_pkg::*;
(
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  // serial link pins
  input  wire logic              SPI_CS_N,
  input  wire logic              SPI_SCK,
  input  wire logic              SPI_DI,
  output logic                   SPI_DO,
  output logic                   SPI_DO_OE,
  // protection and status inputs
  input  wire logic              WRITE_ENABLE_LATCH,
  input  wire logic              PER_UNIT_LOCK_SELECT,
  input  wire logic              RANGE_PROTECTED,
  input  wire logic              EXT_BUSY,
  input  wire logic [UNIT_W-1:0] PROT_UNIT,
  // security register loader
  input  wire flsrc_memwr_type   SECREG_LOAD,
  // status outputs
  output logic                   UNIT_PROTECTED,
  output flsrc_status_type       STATUS
);

  flsrc_state_type   st_reg;
  flsrc_state_type   st_next;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_rise;
  logic              cs_fall;
  logic              di_bit;
  logic [7:0]        op_full;
  logic [23:0]       addr_full;
  logic              op_done;
  logic              mem_rd_en;
  logic [MEM_AW-1:0] mem_rd_addr;
  logic [7:0]        mem_rd_data;
  logic              mem_rd_valid;
  logic              buf_push;
  logic              buf_pop;
  logic              fetching;
  logic [7:0]        out_byte;

  // lock unit selected by an address
  function automatic logic [UNIT_W-1:0] unit_index(
    input logic [23:0] a
  );
    unit_index = a[UNIT_LSB +: UNIT_W];
  endfunction

  // commands gated by the write enable latch
  function automatic logic is_lock_cmd(input logic [7:0] op);
    is_lock_cmd = (op == OP_LOCK_UNIT) || (op == OP_UNLOCK_UNIT) ||
                  (op == OP_GLOBAL_LOCK) || (op == OP_GLOBAL_UNLOCK);
  endfunction

  // pin edges, counted once the second and third stages agree
  assign sck_rise  = st_reg.sck_s[1] & st_reg.sck_s[2] & ~st_reg.sck_f;
  assign sck_fall  = ~st_reg.sck_s[1] & ~st_reg.sck_s[2] & st_reg.sck_f;
  assign cs_rise   = st_reg.cs_s[1] & st_reg.cs_s[2] & ~st_reg.cs_f;
  assign cs_fall   = ~st_reg.cs_s[1] & ~st_reg.cs_s[2] & st_reg.cs_f;
  assign di_bit    = st_reg.di_s[2];
  assign op_full   = {st_reg.opcode[6:0], di_bit};
  assign addr_full = {st_reg.addr[22:0], di_bit};
  assign op_done   = (st_reg.phase == ST_OPCODE) && sck_rise &&
                     !cs_rise &&
                     (st_reg.bit_cnt == 5'(OPCODE_BITS - 1));

  // prefetch into the two-entry buffer while room is guaranteed
  assign fetching  = (st_reg.opcode == OP_READ_SECREG) &&
                     ((st_reg.phase == ST_DUMMY) ||
                      (st_reg.phase == ST_OUT));
  assign mem_rd_en = fetching &&
                     (({1'b0, st_reg.buf_cnt} +
                       {2'b00, st_reg.inflight}) < 3'(BUF_DEPTH));
  // register number 1..3 maps onto the first three of the four array pages
  assign mem_rd_addr = {st_reg.addr[SECREG_SEL_LSB +: 2] - 2'h1,
                        st_reg.rd_byte};
  assign buf_push  = mem_rd_valid && fetching;
  assign buf_pop   = (st_reg.phase == ST_OUT) && sck_fall && !cs_rise &&
                     (st_reg.out_cnt == 3'h0) &&
                     (st_reg.opcode == OP_READ_SECREG) &&
                     (st_reg.buf_cnt != 2'h0);

  flsrc_mem #(
    .AW (MEM_AW),
    .DW (8)
  ) u_mem (
    .clk      (SYS_CLK),
    .rst      (RST),
    .wr       (SECREG_LOAD),
    .rd_en    (mem_rd_en),
    .rd_addr  (mem_rd_addr),
    .rd_data  (mem_rd_data),
    .rd_valid (mem_rd_valid)
  );

  // next-state logic for the whole command interpreter
  always_comb
  begin
    st_next            = st_reg;
    st_next.soft_pulse = 1'b0;

    // three-stage pin synchronisers
    st_next.cs_s  = {st_reg.cs_s[1:0], SPI_CS_N};
    st_next.sck_s = {st_reg.sck_s[1:0], SPI_SCK};
    st_next.di_s  = {st_reg.di_s[1:0], SPI_DI};
    if (st_reg.cs_s[1] == st_reg.cs_s[2])
      st_next.cs_f = st_reg.cs_s[2];
    if (st_reg.sck_s[1] == st_reg.sck_s[2])
      st_next.sck_f = st_reg.sck_s[2];

    // byte address walks and wraps inside the register
    st_next.inflight = mem_rd_en;
    if (mem_rd_en)
      st_next.rd_byte = st_reg.rd_byte + 8'h01;

    // two-entry buffer between array and shifter
    case ({buf_push, buf_pop})
      2'b10:
      begin
        st_next.buf_data[st_reg.buf_cnt[0]] = mem_rd_data;
        st_next.buf_cnt = st_reg.buf_cnt + 2'h1;
      end
      2'b01:
      begin
        st_next.buf_data[0] = st_reg.buf_data[1];
        st_next.buf_cnt     = st_reg.buf_cnt - 2'h1;
      end
      2'b11:
      begin
        st_next.buf_data[0] = (st_reg.buf_cnt == 2'h1) ?
                              mem_rd_data : st_reg.buf_data[1];
        st_next.buf_data[1] = mem_rd_data;
      end
      default:
      begin
      end
    endcase

    // byte for the shifter: lock value or buffered array data
    out_byte = (st_reg.opcode == OP_READ_LOCK) ?
      {7'h00, st_reg.lock[unit_index(st_reg.addr)]} :
      st_reg.buf_data[0];

    if (st_reg.phase == ST_RESETTING)
    begin
      // every frame is rejected until the interval ends
      st_next.rst_cnt = st_reg.rst_cnt - RST_CNT_W'(1);
      if (st_reg.rst_cnt == RST_CNT_W'(1))
        st_next.phase = st_reg.cs_f ? ST_IDLE : ST_WAIT_CS;
    end
    else if (cs_rise)
    begin
      // frame end: stream stops, completed commands execute
      st_next.phase = ST_IDLE;
      if (st_reg.frame_ok && WRITE_ENABLE_LATCH)
      begin
        case (st_reg.opcode)
          OP_LOCK_UNIT:
            st_next.lock[unit_index(st_reg.addr)] = 1'b1;
          OP_UNLOCK_UNIT:
            st_next.lock[unit_index(st_reg.addr)] = 1'b0;
          OP_GLOBAL_LOCK:
            st_next.lock = '1;
          OP_GLOBAL_UNLOCK:
            st_next.lock = '0;
          default:
          begin
          end
        endcase
      end
      if (st_reg.frame_ok && st_reg.rst_armed &&
          (st_reg.opcode == OP_RESET_DEVICE))
      begin
        st_next.phase      = ST_RESETTING;
        st_next.rst_cnt    = RST_CNT_W'(RESET_CYCLES);
        st_next.lock       = {LOCK_UNITS{LOCK_RESET}};
        st_next.rst_armed  = 1'b0;
        st_next.soft_pulse = 1'b1;
        st_next.buf_cnt    = 2'h0;
      end
    end
    else
    begin
      case (st_reg.phase)
        ST_IDLE:
        begin
          if (cs_fall)
          begin
            st_next.phase    = ST_OPCODE;
            st_next.bit_cnt  = 5'h00;
            st_next.frame_ok = 1'b0;
            st_next.buf_cnt  = 2'h0;
          end
        end
        ST_OPCODE:
        begin
          if (sck_rise)
          begin
            st_next.opcode  = op_full;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
          end
          if (op_done)
          begin
            st_next.bit_cnt = 5'h00;
            // anything but the reset pair drops the armed state
            if (op_full == OP_RESET_ENABLE)
              st_next.rst_armed = 1'b1;
            else if (op_full != OP_RESET_DEVICE)
              st_next.rst_armed = 1'b0;
            case (op_full)
              OP_READ_SECREG:
                st_next.phase = EXT_BUSY ? ST_WAIT_CS : ST_ADDR;
              OP_LOCK_UNIT, OP_UNLOCK_UNIT, OP_READ_LOCK:
                st_next.phase = ST_ADDR;
              default:
              begin
                st_next.phase    = ST_WAIT_CS;
                st_next.frame_ok = 1'b1;
              end
            endcase
          end
        end
        ST_ADDR:
        begin
          if (sck_rise)
          begin
            st_next.addr    = addr_full;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == 5'(ADDR_BITS - 1))
            begin
              st_next.bit_cnt = 5'h00;
              st_next.rd_byte = addr_full[7:0];
              st_next.out_cnt = 3'h0;
              case (st_reg.opcode)
                OP_READ_SECREG:
                  st_next.phase = ST_DUMMY;
                OP_READ_LOCK:
                  st_next.phase = ST_OUT;
                default:
                begin
                  st_next.phase    = ST_WAIT_CS;
                  st_next.frame_ok = 1'b1;
                end
              endcase
            end
          end
        end
        ST_DUMMY:
        begin
          // the host clocks eight dummy bits before data
          if (sck_rise)
          begin
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == 5'(DUMMY_BITS - 1))
              st_next.phase = ST_OUT;
          end
        end
        ST_OUT:
        begin
          // shift out on falling edges, most significant bit first
          if (sck_fall)
          begin
            st_next.out_cnt = st_reg.out_cnt + 3'h1;
            if (st_reg.out_cnt == 3'h0)
            begin
              st_next.do_bit = out_byte[7];
              st_next.out_sh = {out_byte[6:0], 1'b0};
            end
            else
            begin
              st_next.do_bit = st_reg.out_sh[7];
              st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
            end
          end
        end
        ST_WAIT_CS:
        begin
        end
        default:
          st_next.phase = ST_IDLE;
      endcase
    end
  end

  // state register, lock bits power up set
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_reg       <= '0;
      st_reg.cs_s  <= 3'h7;
      st_reg.cs_f  <= 1'b1;
      st_reg.lock  <= {LOCK_UNITS{LOCK_RESET}};
    end
    else
      st_reg <= st_next;
  end

  // pin and status outputs
  assign SPI_DO         = st_reg.do_bit;
  assign SPI_DO_OE      = (st_reg.phase == ST_OUT);
  assign UNIT_PROTECTED = PER_UNIT_LOCK_SELECT ?
                          st_reg.lock[PROT_UNIT] : RANGE_PROTECTED;
  assign STATUS = '{busy:        EXT_BUSY |
                                 (st_reg.phase == ST_RESETTING),
                    soft_reset:  st_reg.soft_pulse,
                    reset_armed: st_reg.rst_armed};

  // checks on the interpreter
  localparam int A_RST_LAST = RESET_CYCLES - 1;
  localparam int A_RST_END  = RESET_CYCLES;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  a_reset_defaults: assert property (
    st_reg.soft_pulse |-> (&st_reg.lock))
    else $error("lock bits not all set after software reset");

  a_reset_hold: assert property (
    st_reg.soft_pulse |-> ##A_RST_LAST STATUS.busy)
    else $error("reset interval ended early");

  a_reset_ends: assert property (
    (st_reg.soft_pulse && !EXT_BUSY) |-> ##A_RST_END
      (st_reg.phase != ST_RESETTING))
    else $error("reset interval overran");

  a_reset_pair: assert property (
    st_reg.soft_pulse |-> $past(st_reg.rst_armed) &&
      ($past(st_reg.opcode) == OP_RESET_DEVICE))
    else $error("reset without armed reset pair");

  a_armed_drop: assert property (
    (op_done && (op_full != OP_RESET_ENABLE) &&
     (op_full != OP_RESET_DEVICE)) |=> !st_reg.rst_armed)
    else $error("armed reset survived another command");

  a_busy_ignore: assert property (
    (op_done && (op_full == OP_READ_SECREG) && EXT_BUSY)
      |=> (st_reg.phase == ST_WAIT_CS) && !st_reg.frame_ok)
    else $error("register read accepted while busy");

  a_wel_gate: assert property (
    (cs_rise && !WRITE_ENABLE_LATCH && st_reg.frame_ok &&
     is_lock_cmd(st_reg.opcode) && (st_reg.phase != ST_RESETTING))
      |=> $stable(st_reg.lock))
    else $error("lock bits changed without write enable");

  a_global_clear: assert property (
    (cs_rise && WRITE_ENABLE_LATCH && st_reg.frame_ok &&
     (st_reg.opcode == OP_GLOBAL_UNLOCK) &&
     (st_reg.phase != ST_RESETTING)) |=> (st_reg.lock == '0))
    else $error("global unlock left a bit set");

  a_addr_wrap: assert property (
    (mem_rd_en && (st_reg.rd_byte == 8'hFF)) |=>
      (st_reg.rd_byte == 8'h00))
    else $error("byte address did not wrap");

  a_out_falling: assert property (
    ((st_reg.phase == ST_OUT) && !sck_fall) |=> $stable(SPI_DO))
    else $error("data changed away from a falling edge");

  a_lock_lsb: assert property (
    ((st_reg.phase == ST_OUT) && sck_fall && !cs_rise &&
     (st_reg.out_cnt == 3'h7) && (st_reg.opcode == OP_READ_LOCK))
      |=> (SPI_DO == st_reg.lock[unit_index(st_reg.addr)]))
    else $error("lock value LSB wrong");

  c_soft_reset: cover property (st_reg.soft_pulse);
  c_secreg_pop: cover property (buf_pop ##[1:100] buf_pop);
  c_lock_read: cover property (
    (st_reg.phase == ST_OUT) && (st_reg.opcode == OP_READ_LOCK));
  c_unlock_one: cover property (
    cs_rise && WRITE_ENABLE_LATCH && st_reg.frame_ok &&
    (st_reg.opcode == OP_UNLOCK_UNIT));

endmodule

// file: flsrc_host.sv
`timescale 1ns/100ps
module flsrc_host
(
  // system clock
  input  wire logic        clk,
  // serial link toward the device
  output logic             cs_n,
  output logic             sck,
  output logic             di,
  input  wire logic        do_in,
  // word read back in the last frame
  output logic             rx_stb,
  output logic [31:0]      rx_word
);
  // idle link at time zero
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    di = 1'b0;
    rx_stb = 1'b0;
    rx_word = '0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one frame: ntx bits msb first, then nrx bits sampled on do_in
  task automatic xfer(input logic [63:0] tx, input int ntx,
                      input int nrx, input bit keep);
    logic [31:0] rx;
    rx = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    wt(4);
    for (int i = 0; i < ntx + nrx; i++)
    begin
      sck <= 1'b0;
      di <= (i < ntx) ? tx[ntx-1-i] : ~di;
      wt(4);
      sck <= 1'b1;
      wt(3);
      if (i >= ntx)
        rx = {rx[30:0], do_in};
      wt(1);
    end
    sck <= 1'b0;
    wt(4);
    cs_n <= 1'b1;
    di <= ~di;
    wt(8);
    rx_word <= rx;
    rx_stb <= keep;
    wt(1);
    rx_stb <= 1'b0;
  endtask
endmodule

// file: tb_flsrc_core.sv
`timescale 1ns/100ps
module tb_flsrc_core
  import flsrc_pkg::*;
;
  logic                  sys_clk;
  logic                  rst;
  logic                  cs_n;
  logic                  sck;
  logic                  di;
  logic                  spi_do;
  logic                  spi_do_oe;
  logic                  wr_latch;
  logic                  sel;
  logic                  range_p;
  logic                  ext_busy;
  logic [UNIT_W-1:0]     prot_unit;
  flsrc_memwr_type       load;
  logic                  unit_prot;
  flsrc_status_type      status;
  logic                  rx_stb;
  logic [31:0]           rx_word;
  int                    error_cnt;
  int                    checks_done;
  int                    busy_cnt;
  int                    soft_cnt;
  bit                    oe_seen;
  logic [31:0]           exp_q[$];
  logic [7:0]            mem [0:767];
  logic [LOCK_UNITS-1:0] exp_lock;
  logic [7:0]            off;
  logic [31:0]           e;
  logic [UNIT_W-1:0]     u;
  logic [8:0]            tbl [10] = '{9'h098, 9'h139, 9'h036, 9'h136,
    9'h198, 9'h07E, 9'h136, 9'h039, 9'h17E, 9'h198};

  flsrc_core u_flsrc_core
  (
    .SYS_CLK              (sys_clk),
    .RST                  (rst),
    .SPI_CS_N             (cs_n),
    .SPI_SCK              (sck),
    .SPI_DI               (di),
    .SPI_DO               (spi_do),
    .SPI_DO_OE            (spi_do_oe),
    .WRITE_ENABLE_LATCH   (wr_latch),
    .PER_UNIT_LOCK_SELECT (sel),
    .RANGE_PROTECTED      (range_p),
    .EXT_BUSY             (ext_busy),
    .PROT_UNIT            (prot_unit),
    .SECREG_LOAD          (load),
    .UNIT_PROTECTED       (unit_prot),
    .STATUS               (status)
  );

  flsrc_host u_flsrc_host
  (
    .clk     (sys_clk),
    .cs_n    (cs_n),
    .sck     (sck),
    .di      (di),
    .do_in   (spi_do),
    .rx_stb  (rx_stb),
    .rx_word (rx_word)
  );

  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watcher: read results against the oldest note, flags and counts
  always @(negedge sys_clk)
  begin
    if (spi_do_oe === 1'b1)
      oe_seen = 1'b1;
    if (status.busy === 1'b1 && ext_busy === 1'b0)
      busy_cnt++;
    if (status.soft_reset === 1'b1)
      soft_cnt++;
    if (rx_stb === 1'b1)
      check("spi read", rx_word, exp_q.pop_front());
  end

  // command frame plus the expected effect on the lock bits
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    bit ok;
    @(negedge sys_clk);
    ok = (wr_latch === 1'b1) && (status.busy !== 1'b1);
    if (op == OP_LOCK_UNIT || op == OP_UNLOCK_UNIT)
      u_flsrc_host.xfer({32'h0, op, a}, 32, 0, 1'b0);
    else
      u_flsrc_host.xfer({56'h0, op}, 8, 0, 1'b0);
    if (ok && op == OP_LOCK_UNIT)
      exp_lock[a[21:16]] = 1'b1;
    if (ok && op == OP_UNLOCK_UNIT)
      exp_lock[a[21:16]] = 1'b0;
    if (ok && op == OP_GLOBAL_LOCK)
      exp_lock = '1;
    if (ok && op == OP_GLOBAL_UNLOCK)
      exp_lock = '0;
  endtask

  task automatic chk_unit(input logic [UNIT_W-1:0] k);
    @(posedge sys_clk);
    prot_unit <= k;
    @(negedge sys_clk);
    check("unit protected", unit_prot, exp_lock[k]);
  endtask

  task automatic rd_lock(input logic [UNIT_W-1:0] k);
    exp_q.push_back({31'h0, exp_lock[k]});
    u_flsrc_host.xfer({32'h0, OP_READ_LOCK, 2'b00, k, 16'h0}, 32, 8, 1'b1);
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    wr_latch = 1'b0;
    sel = 1'b1;
    range_p = 1'b0;
    ext_busy = 1'b0;
    prot_unit = '0;
    load = '0;
    error_cnt = 0;
    checks_done = 0;
    busy_cnt = 0;
    soft_cnt = 0;
    exp_lock = '1;
    void'($urandom(32'h26be0da6));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // fill all three registers with random bytes
    for (int i = 0; i < 768; i++)
    begin
      mem[i] = 8'($urandom);
      @(posedge sys_clk);
      load <= '{en: 1'b1, addr: i[9:0], data: mem[i]};
    end
    @(posedge sys_clk);
    load <= '0;
    chk_unit(6'($urandom));
    // range path while per-unit select is low
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      sel <= 1'b0;
      range_p <= k[0];
      @(negedge sys_clk);
      check("range protect", unit_prot, k[0]);
    end
    @(posedge sys_clk);
    sel <= 1'b1;
    // three four-byte streams, register two crossing the wrap
    for (int r = 1; r <= 3; r++)
    begin
      off = (r == 2) ? 8'hFE : 8'($urandom);
      e = '0;
      for (int b = 0; b < 4; b++)
        e = {e[23:0], mem[(r - 1) * 256 + int'(8'(off + b))]};
      exp_q.push_back(e);
      oe_seen = 1'b0;
      u_flsrc_host.xfer({24'h0, OP_READ_SECREG, 8'h00, 4'(r), 4'h0, off,
        8'h00}, 40, 32, 1'b1);
      check("oe in read", oe_seen, 1'b1);
    end
    // register read refused while a cycle runs
    @(posedge sys_clk);
    ext_busy <= 1'b1;
    oe_seen = 1'b0;
    u_flsrc_host.xfer({24'h0, OP_READ_SECREG, 24'h001000, 8'h00}, 40, 16,
      1'b0);
    check("oe while busy", oe_seen, 1'b0);
    check("busy ext", status.busy, 1'b1);
    @(posedge sys_clk);
    ext_busy <= 1'b0;
    // lock commands with and without write enable latch
    u = 6'($urandom);
    for (int j = 0; j < 10; j++)
    begin
      @(posedge sys_clk);
      wr_latch <= tbl[j][8];
      cmd(tbl[j][7:0], {2'b00, u, 16'h0});
      chk_unit(u);
      chk_unit(u + 6'h01);
      rd_lock(u);
    end
    // broken reset pair does nothing
    cmd(OP_RESET_ENABLE, 24'h0);
    check("armed", status.reset_armed, 1'b1);
    rd_lock(u);
    check("disarmed", status.reset_armed, 1'b0);
    cmd(OP_RESET_DEVICE, 24'h0);
    check("soft reset", soft_cnt, 0);
    chk_unit(u);
    check("idle before reset", status.busy, 1'b0);
    // full reset pair, then a refused command meanwhile
    busy_cnt = 0;
    cmd(OP_RESET_ENABLE, 24'h0);
    cmd(OP_RESET_DEVICE, 24'h0);
    exp_lock = '1;
    check("soft reset", soft_cnt, 1);
    cmd(OP_GLOBAL_UNLOCK, 24'h0);
    chk_unit(u);
    repeat (RESET_CYCLES) @(posedge sys_clk);
    @(negedge sys_clk);
    check("busy after reset", status.busy, 1'b0);
    check("reset length", busy_cnt, RESET_CYCLES);
    wrap_up();
  end

  // watchdog
  initial
  begin
    #5000000;
    error_cnt++;
    wrap_up();
  end
endmodule
